/* verilog/acc_pkg.sv */
// Package: register map, field positions, reset values and enums of the
// calibration control register bank.
// Assumes an 8-bit register port with byte-wide registers at the offsets below.
package acc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_AVG     = 8'h68;
  localparam logic [7:0] ADDR_STATUS  = 8'h6A;
  localparam logic [7:0] ADDR_PINCFG  = 8'h6B;
  localparam logic [7:0] ADDR_SWTRIG  = 8'h6C;
  localparam logic [7:0] ADDR_LP      = 8'h6E;
  localparam logic [7:0] ADDR_CTRL    = 8'h70;
  localparam logic [7:0] ADDR_IRQSTS  = 8'h71;
  localparam logic [7:0] ADDR_IRQMASK = 8'h72;

  // Reset values
  localparam logic [7:0] AVG_RST     = 8'h61;
  localparam logic [7:0] PINCFG_RST  = 8'h00;
  localparam logic [7:0] SWTRIG_RST  = 8'h01;
  localparam logic [7:0] LP_RST      = 8'h88;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] IRQMASK_RST = 8'h00;
  localparam logic [2:0] IRQSTS_RST  = 3'h0;
  localparam logic [2:0] STCODE_RST  = 3'h0;

  // Field positions
  localparam int OFFAVG_LSB  = 4;
  localparam int LINAVG_LSB  = 0;
  localparam int AVG_W       = 3;
  localparam int STCODE_LSB  = 2;
  localparam int STCODE_W    = 3;
  localparam int HALT_BIT    = 1;
  localparam int FGCPL_BIT   = 0;
  localparam int PINSEL_LSB  = 1;
  localparam int TRIGSEL_BIT = 0;
  localparam int SWTRIG_BIT  = 0;
  localparam int LPEN_BIT    = 0;
  localparam int SLPTRIG_BIT = 1;
  localparam int BGEN_BIT    = 0;
  localparam int IRQ_FG      = 0;
  localparam int IRQ_HALT    = 1;
  localparam int IRQ_ALARM   = 2;
  localparam int IRQ_W       = 3;

  // Status pin source
  typedef enum logic [1:0] {
    PIN_FGCPL  = 2'h0,
    PIN_HALTED = 2'h1,
    PIN_ALARM  = 2'h2,
    PIN_LOW    = 2'h3
  } acc_pinsel_t;

  // Calibration phase tracker, Gray along foreground, background, halted
  typedef enum logic [1:0] {
    ST_FG   = 2'h0,
    ST_BG   = 2'h1,
    ST_HALT = 2'h3
  } acc_state_t;

endpackage

/* verilog/acc_trig_sel.sv */
// Calibration trigger source selection.
// Assumes the hardware trigger pin is synchronous to clk.
`timescale 1ns/1ps
module acc_trig_sel (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigSourceSelect,
  input  wire logic softwareTriggerBit,
  input  wire logic triggerInputPin,
  output logic      calTrigger
);

  logic calTrigger_d;

  always_comb begin
    if (trigSourceSelect) begin
      calTrigger_d = triggerInputPin;     // [RULE_11]
    end else begin
      calTrigger_d = softwareTriggerBit;  // [RULE_10] [RULE_12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calTrigger <= 1'b1;
    end else begin
      calTrigger <= calTrigger_d;
    end
  end

endmodule

/* verilog/acc_stat_pin.sv */
// Status output pin source multiplexer, registered.
// Assumes flag inputs are synchronous to clk.
`timescale 1ns/1ps
module acc_stat_pin (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] pinSelect,
  input  wire logic       fgComplete,
  input  wire logic       bgHalted,
  input  wire logic       alarm,
  output logic            statusOutputPin
);

  logic pin_d;

  always_comb begin
    case (acc_pkg::acc_pinsel_t'(pinSelect))  // [RULE_09]
      acc_pkg::PIN_FGCPL:  pin_d = fgComplete;
      acc_pkg::PIN_HALTED: pin_d = bgHalted;
      acc_pkg::PIN_ALARM:  pin_d = alarm;
      acc_pkg::PIN_LOW:    pin_d = 1'b0;
      default:             pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusOutputPin <= 1'b0;
    end else begin
      statusOutputPin <= pin_d;
    end
  end

endmodule

/* verilog/acc_cal_regs.sv */
// Calibration control and status register bank with interrupt logic.
// Assumes a one-cycle strobe register port and an external calibration
// engine reporting foreground done, background stopped, status code and alarm.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

// Operation
// RULE_01 - Offset averaging depth, bits 6:4, reset 6
// RULE_02 - Linearity averaging depth, bits 2:0, reset 1
// RULE_03 - Software writes reserved bits with defaults
// RULE_04 - Status register read-only, code bits 4:2
// RULE_05 - Halted flag set when background stops
// RULE_06 - Halted flag clears when calibration resumes
// RULE_07 - Background off: halted follows foreground finish
// RULE_08 - Foreground-complete flag set on finish/skip
// RULE_09 - Pin source field selects status pin
// RULE_10 - Select 0: software trigger, pin ignored
// RULE_11 - Select 1: hardware pin, software ignored
// RULE_12 - Software trigger bit 0, reset 1
// RULE_13 - Unused trigger: select 0, bit 1
// RULE_14 - Trigger mode: wake ADC while trigger low
// RULE_15 - Background enable bit gates background calibration
// RULE_16 - Status register writes have no effect
module acc_cal_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              triggerInputPin,
  input  wire logic              engFgComplete,
  input  wire logic              engBgStopped,
  input  wire logic [2:0]        engStatusCode,
  input  wire logic              alarmIn,
  input  wire logic              calRestart,
  output logic                   statusOutputPin,
  output logic                   calTrigger,
  output logic      [2:0]        offsetAverageDepth,
  output logic      [2:0]        linearityAverageDepth,
  output logic                   backgroundCalEnable,
  output logic                   adcWake,
  output logic                   irq
);

  // Elaboration checks
  if (ADDR_W != 8) begin : gChkAddr
    $error("acc_cal_regs: ADDR_W must be 8");
  end
  if (DATA_W != 8) begin : gChkData
    $error("acc_cal_regs: DATA_W must be 8");
  end

  function automatic logic isHit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    isHit = (a == off);
  endfunction

  // Software registers
  logic [7:0] avg_q;
  logic [7:0] avg_d;
  logic [7:0] pinCfg_q;
  logic [7:0] pinCfg_d;
  logic [7:0] swTrig_q;
  logic [7:0] swTrig_d;
  logic [7:0] lp_q;
  logic [7:0] lp_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] irqMask_q;
  logic [7:0] irqMask_d;

  // Status tracking
  acc_pkg::acc_state_t state_q;
  acc_pkg::acc_state_t state_d;
  logic                fgCpl_q;
  logic                fgCpl_d;
  logic                halted_q;
  logic                halted_d;
  logic [2:0]          stCode_q;
  logic [2:0]          stCode_d;
  logic                alarm_q;
  logic                alarm_d;

  // Interrupts and read data
  logic [2:0]          irqSts_q;
  logic [2:0]          irqSts_d;
  logic [2:0]          irqEvt;
  logic [2:0]          irqClr;
  logic                irq_d;
  logic [DATA_W-1:0]   rdata_d;
  logic                adcWake_d;
  logic                bgEn;
  logic                sleepTrigMode;

  assign bgEn          = ctrl_q[acc_pkg::BGEN_BIT];
  assign sleepTrigMode = lp_q[acc_pkg::LPEN_BIT] & lp_q[acc_pkg::SLPTRIG_BIT] & bgEn;

  // Register writes
  always_comb begin
    avg_d     = avg_q;
    pinCfg_d  = pinCfg_q;
    swTrig_d  = swTrig_q;
    lp_d      = lp_q;
    ctrl_d    = ctrl_q;
    irqMask_d = irqMask_q;
    if (regWrite) begin
      if (isHit(regAddr, acc_pkg::ADDR_AVG)) begin
        avg_d = regWdata;  // [RULE_01] [RULE_02]
      end
      if (isHit(regAddr, acc_pkg::ADDR_PINCFG)) begin
        pinCfg_d = regWdata;
      end
      if (isHit(regAddr, acc_pkg::ADDR_SWTRIG)) begin
        swTrig_d = regWdata;  // [RULE_12]
      end
      if (isHit(regAddr, acc_pkg::ADDR_LP)) begin
        lp_d = regWdata;
      end
      if (isHit(regAddr, acc_pkg::ADDR_CTRL)) begin
        ctrl_d = regWdata;  // [RULE_15]
      end
      if (isHit(regAddr, acc_pkg::ADDR_IRQMASK)) begin
        irqMask_d = regWdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avg_q     <= acc_pkg::AVG_RST;
      pinCfg_q  <= acc_pkg::PINCFG_RST;
      swTrig_q  <= acc_pkg::SWTRIG_RST;
      lp_q      <= acc_pkg::LP_RST;
      ctrl_q    <= acc_pkg::CTRL_RST;
      irqMask_q <= acc_pkg::IRQMASK_RST;
    end else begin
      avg_q     <= avg_d;
      pinCfg_q  <= pinCfg_d;
      swTrig_q  <= swTrig_d;
      lp_q      <= lp_d;
      ctrl_q    <= ctrl_d;
      irqMask_q <= irqMask_d;
    end
  end

  assign offsetAverageDepth    = avg_q[acc_pkg::OFFAVG_LSB +: acc_pkg::AVG_W];  // [RULE_01]
  assign linearityAverageDepth = avg_q[acc_pkg::LINAVG_LSB +: acc_pkg::AVG_W];  // [RULE_02]
  assign backgroundCalEnable   = ctrl_q[acc_pkg::BGEN_BIT];                     // [RULE_15]

  // Calibration phase and status flags
  always_comb begin
    state_d  = state_q;
    fgCpl_d  = fgCpl_q;
    halted_d = halted_q;
    stCode_d = engStatusCode;
    alarm_d  = alarmIn;
    if (calRestart) begin
      state_d  = acc_pkg::ST_FG;
      fgCpl_d  = 1'b0;
      halted_d = 1'b0;
    end else begin
      case (state_q)
        acc_pkg::ST_FG: begin
          if (engFgComplete) begin
            fgCpl_d = 1'b1;  // [RULE_08]
            if (bgEn) begin
              state_d = acc_pkg::ST_BG;
            end else begin
              state_d  = acc_pkg::ST_HALT;
              halted_d = 1'b1;  // [RULE_07]
            end
          end
        end
        acc_pkg::ST_BG: begin
          if (!bgEn) begin
            state_d  = acc_pkg::ST_HALT;
            halted_d = 1'b1;  // [RULE_07]
          end else if (engBgStopped) begin
            state_d  = acc_pkg::ST_HALT;
            halted_d = 1'b1;  // [RULE_05]
          end
        end
        acc_pkg::ST_HALT: begin
          if (bgEn && !engBgStopped) begin
            state_d  = acc_pkg::ST_BG;
            halted_d = 1'b0;  // [RULE_06]
          end
        end
        default: begin
          state_d  = acc_pkg::ST_FG;
          fgCpl_d  = 1'b0;
          halted_d = 1'b0;
        end
      endcase
    end
  end

  // Status register has no write path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= acc_pkg::ST_FG;
      fgCpl_q  <= 1'b0;
      halted_q <= 1'b0;
      stCode_q <= acc_pkg::STCODE_RST;
      alarm_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      fgCpl_q  <= fgCpl_d;    // [RULE_16]
      halted_q <= halted_d;
      stCode_q <= stCode_d;   // [RULE_04]
      alarm_q  <= alarm_d;
    end
  end

  // Sticky interrupt status, set beats clear
  always_comb begin
    irqEvt = '0;
    irqEvt[acc_pkg::IRQ_FG]    = fgCpl_d & ~fgCpl_q;
    irqEvt[acc_pkg::IRQ_HALT]  = halted_d & ~halted_q;
    irqEvt[acc_pkg::IRQ_ALARM] = alarmIn & ~alarm_q;
    irqClr = '0;
    if (regWrite && isHit(regAddr, acc_pkg::ADDR_IRQSTS)) begin
      irqClr = regWdata[acc_pkg::IRQ_W-1:0];
    end
    irqSts_d = (irqSts_q & ~irqClr) | irqEvt;
    irq_d    = |(irqSts_q & irqMask_q[acc_pkg::IRQ_W-1:0]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSts_q <= acc_pkg::IRQSTS_RST;
      irq      <= 1'b0;
    end else begin
      irqSts_q <= irqSts_d;
      irq      <= irq_d;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (regRead) begin
      if (isHit(regAddr, acc_pkg::ADDR_AVG)) begin
        rdata_d = avg_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_STATUS)) begin
        rdata_d[acc_pkg::STCODE_LSB +: acc_pkg::STCODE_W] = stCode_q;  // [RULE_04]
        rdata_d[acc_pkg::HALT_BIT]   = halted_q;                        // [RULE_05]
        rdata_d[acc_pkg::FGCPL_BIT]  = fgCpl_q;                         // [RULE_08]
      end
      if (isHit(regAddr, acc_pkg::ADDR_PINCFG)) begin
        rdata_d = pinCfg_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_SWTRIG)) begin
        rdata_d = swTrig_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_LP)) begin
        rdata_d = lp_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_CTRL)) begin
        rdata_d = ctrl_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_IRQSTS)) begin
        rdata_d[acc_pkg::IRQ_W-1:0] = irqSts_q;
      end
      if (isHit(regAddr, acc_pkg::ADDR_IRQMASK)) begin
        rdata_d = irqMask_q;
      end
    end
  end

  // Sleep-until-trigger wake control
  always_comb begin
    if (sleepTrigMode) begin
      adcWake_d = ~calTrigger;  // [RULE_14]
    end else begin
      adcWake_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
      adcWake  <= 1'b1;
    end else begin
      regRdata <= rdata_d;
      adcWake  <= adcWake_d;
    end
  end

  // Trigger source
  acc_trig_sel uTrig (
    .clk                (clk),
    .rst_n              (rst_n),
    .trigSourceSelect   (pinCfg_q[acc_pkg::TRIGSEL_BIT]),  // [RULE_10] [RULE_11]
    .softwareTriggerBit (swTrig_q[acc_pkg::SWTRIG_BIT]),
    .triggerInputPin    (triggerInputPin),
    .calTrigger         (calTrigger)
  );

  // Status pin
  acc_stat_pin uPin (
    .clk             (clk),
    .rst_n           (rst_n),
    .pinSelect       (pinCfg_q[acc_pkg::PINSEL_LSB +: 2]),  // [RULE_09]
    .fgComplete      (fgCpl_q),
    .bgHalted        (halted_q),
    .alarm           (alarm_q),
    .statusOutputPin (statusOutputPin)
  );

endmodule

/* dv/acc_cal_regs_chk.sv */
// Checker for the calibration register bank, bound to its top module.
// Assumes the one-cycle strobe register port and shadows written fields.
`timescale 1ns/1ps
module acc_cal_regs_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       triggerInputPin,
  input wire logic       engFgComplete,
  input wire logic       engBgStopped,
  input wire logic       alarmIn,
  input wire logic       calRestart,
  input wire logic       statusOutputPin,
  input wire logic       calTrigger,
  input wire logic [2:0] offsetAverageDepth,
  input wire logic [2:0] linearityAverageDepth,
  input wire logic       backgroundCalEnable,
  input wire logic       adcWake,
  input wire logic       irq
);
  logic       selQ, swQ, lpEn, sleepTrig, bgQ;
  logic [1:0] pinSel;
  logic [2:0] maskQ;
  wire  logic trigD = selQ ? triggerInputPin : swQ;
  wire  logic wakeD = (lpEn && sleepTrig && bgQ) ? !calTrigger : 1'b1;
  wire  logic avgWr = regWrite && regAddr == 8'h68;

  // Shadow copies of the written control fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {pinSel, selQ} <= 3'h0;
      swQ <= 1'b1;
      {sleepTrig, lpEn} <= 2'h0;
      bgQ <= 1'b0;
      maskQ <= 3'h0;
    end else if (regWrite) begin
      if (regAddr == 8'h6B) {pinSel, selQ} <= regWdata[2:0];
      if (regAddr == 8'h6C) swQ <= regWdata[0];
      if (regAddr == 8'h6E) {sleepTrig, lpEn} <= regWdata[1:0];
      if (regAddr == 8'h70) bgQ <= regWdata[0];
      if (regAddr == 8'h72) maskQ <= regWdata[2:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sFg;
    engFgComplete && !calRestart && pinSel == 2'h0;
  endsequence
  sequence sFgHold;
    !calRestart && pinSel == 2'h0;
  endsequence
  sequence sRun;
    bgQ && !engBgStopped && pinSel == 2'h1;
  endsequence

  AST_AVG_WR: assert property (avgWr |=> {1'b0, offsetAverageDepth, 1'b0, linearityAverageDepth} ==
    ($past(regWdata) & 8'h77)) else $error("averaging depths differ from written value");
  AST_AVG_HOLD: assert property (!avgWr |=> $stable(offsetAverageDepth) && $stable(linearityAverageDepth))
    else $error("averaging depth moved without a write");
  AST_TRIG: assert property (calTrigger == $past(trigD))
    else $error("trigger not from selected source");
  AST_WAKE: assert property (adcWake == $past(wakeD)) else $error("wake level wrong");
  AST_BG_EN: assert property (backgroundCalEnable == bgQ) else $error("background enable wrong");
  AST_PIN_LOW: assert property (pinSel == 2'h3 |=> !statusOutputPin) else $error("pin not low");
  AST_PIN_FG: assert property (sFg ##1 sFgHold |=> statusOutputPin) else $error("pin missed done");
  AST_PIN_ALARM: assert property (alarmIn && pinSel == 2'h2 ##1 pinSel == 2'h2 |=> statusOutputPin)
    else $error("pin missed alarm");
  AST_HALT_CLR: assert property (sRun ##1 sRun |=> !statusOutputPin) else $error("halted kept");
  AST_IRQ_MASK: assert property (maskQ == 3'h0 |=> !irq) else $error("masked interrupt raised");
endmodule

bind acc_cal_regs acc_cal_regs_chk chk (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .triggerInputPin,
  .engFgComplete, .engBgStopped, .alarmIn, .calRestart, .statusOutputPin, .calTrigger, .offsetAverageDepth,
  .linearityAverageDepth, .backgroundCalEnable, .adcWake, .irq);

/* dv/acc_host_model.sv */
// Far-side model: trigger pin driver and calibration engine events.
// Assumes its caller sequences it through the tasks below.
`timescale 1ns/1ps
module acc_host_model (
  input wire logic   clk,
  output logic       triggerInputPin,
  output logic       engFgComplete,
  output logic       engBgStopped,
  output logic [2:0] engStatusCode,
  output logic       alarmIn,
  output logic       calRestart
);
  initial begin
    {triggerInputPin, engFgComplete, engBgStopped, alarmIn, calRestart} = 5'h00;
    engStatusCode = 3'h0;
  end

  // Levels change just after an edge, synchronous to clk
  task automatic set(input logic t, s, a, input logic [2:0] c);
    @(posedge clk) begin
      triggerInputPin <= t;
      engBgStopped <= s;
      alarmIn <= a;
      engStatusCode <= c;
    end
  endtask

  task automatic fg;
    @(posedge clk) engFgComplete <= 1'b1;
    @(posedge clk) engFgComplete <= 1'b0;
  endtask

  task automatic restart;
    @(posedge clk) calRestart <= 1'b1;
    @(posedge clk) calRestart <= 1'b0;
  endtask
endmodule

/* dv/acc_cal_regs_bench.sv */
// Self-checking bench for the calibration register bank.
// Assumes the host model and the bound checker alongside.
`timescale 1ns/1ps
module acc_cal_regs_bench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata;
  logic       triggerInputPin, engFgComplete, engBgStopped, alarmIn, calRestart;
  logic [2:0] engStatusCode, offsetAverageDepth, linearityAverageDepth;
  logic       statusOutputPin, calTrigger, backgroundCalEnable, adcWake, irq;
  int         failures = 0;
  int         check_count = 0;
  int         cyc = 0;

  always #20 clk = ~clk;

  acc_cal_regs dut (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .triggerInputPin,
    .engFgComplete, .engBgStopped, .engStatusCode, .alarmIn, .calRestart, .statusOutputPin, .calTrigger,
    .offsetAverageDepth, .linearityAverageDepth, .backgroundCalEnable, .adcWake, .irq);
  acc_host_model m (.clk, .triggerInputPin, .engFgComplete, .engBgStopped, .engStatusCode, .alarmIn,
    .calRestart);

  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      summarize;
    end
  end

  task automatic chkReg(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: read %h want %h", $time, got, exp);
    end
  endtask

  task automatic chkOut(input logic [2:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: output %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) begin
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
    end
    @(posedge clk) regWrite <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, exp);
    @(posedge clk) begin
      regRead <= 1'b1;
      regAddr <= a;
    end
    @(posedge clk) regRead <= 1'b0;
    #1 chkReg(regRdata, exp);
  endtask

  task automatic tReset;
    rdc(8'h68, 8'h61);
    rdc(8'h6A, 8'h00);
    rdc(8'h6B, 8'h00);
    rdc(8'h6C, 8'h01);
    rdc(8'h6E, 8'h88);
    rdc(8'h69, 8'h00);
    chkOut(offsetAverageDepth, 3'h6);
    chkOut(linearityAverageDepth, 3'h1);
    chkOut({2'b0, calTrigger}, 3'h1);
  endtask

  task automatic tAvg;
    wr(8'h68, 8'h75);
    chkOut(offsetAverageDepth, 3'h7);
    chkOut(linearityAverageDepth, 3'h5);
    rdc(8'h68, 8'h75);
    wr(8'h68, 8'h61);
  endtask

  task automatic tTrig;
    m.set(1'b1, 1'b0, 1'b0, 3'h0);
    wr(8'h6C, 8'h00);
    tick(1);
    chkOut({2'b0, calTrigger}, 3'h0);
    wr(8'h6B, 8'h01);
    tick(1);
    chkOut({2'b0, calTrigger}, 3'h1);
    wr(8'h6E, 8'h8B);
    wr(8'h70, 8'h01);
    chkOut({2'b0, backgroundCalEnable}, 3'h1);
    tick(1);
    chkOut({2'b0, adcWake}, 3'h0);
    m.set(1'b0, 1'b0, 1'b0, 3'h0);
    tick(1);
    chkOut({2'b0, calTrigger}, 3'h0);
    tick(1);
    chkOut({2'b0, adcWake}, 3'h1);
    wr(8'h6B, 8'h00);
    wr(8'h6C, 8'h01);
    wr(8'h6E, 8'h88);
    wr(8'h70, 8'h00);
  endtask

  task automatic tFlags;
    m.restart();
    m.set(1'b0, 1'b0, 1'b0, 3'h5);
    m.fg();
    rdc(8'h6A, 8'h17);
    chkOut({2'b0, irq}, 3'h0);
    rdc(8'h71, 8'h03);
    wr(8'h6A, 8'h00);
    rdc(8'h6A, 8'h17);
    for (int s = 0; s < 4; s++) begin
      wr(8'h6B, 8'(s << 1));
      tick(1);
      chkOut({2'b0, statusOutputPin}, {2'b0, s < 2});
    end
    wr(8'h6B, 8'h00);
  endtask

  task automatic tBg;
    wr(8'h70, 8'h01);
    wr(8'h6B, 8'h02);
    m.restart();
    rdc(8'h6A, 8'h14);
    m.fg();
    rdc(8'h6A, 8'h15);
    m.set(1'b0, 1'b1, 1'b0, 3'h5);
    rdc(8'h6A, 8'h17);
    m.set(1'b0, 1'b0, 1'b0, 3'h5);
    rdc(8'h6A, 8'h15);
    chkOut({2'b0, statusOutputPin}, 3'h0);
    wr(8'h6B, 8'h00);
    wr(8'h70, 8'h00);
  endtask

  task automatic tIrq;
    wr(8'h71, 8'h07);
    rdc(8'h71, 8'h00);
    wr(8'h72, 8'h04);
    wr(8'h6B, 8'h04);
    m.set(1'b0, 1'b0, 1'b1, 3'h5);
    tick(3);
    chkOut({2'b0, irq}, 3'h1);
    chkOut({2'b0, statusOutputPin}, 3'h1);
    rdc(8'h71, 8'h04);
    wr(8'h71, 8'h04);
    tick(2);
    chkOut({2'b0, irq}, 3'h0);
    wr(8'h72, 8'h00);
    wr(8'h6B, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tReset;
    tAvg;
    tTrig;
    tFlags;
    tBg;
    tIrq;
    summarize;
  end
endmodule
